//--- rsc_err_policy.sv
// Error policy sequencer for one port: immediate, delayed, recoverable or ignored.
// Assumes err_i is already qualified by the link-run condition and tick_i is a 1 ms pulse.
`timescale 1ns/1ps
`default_nettype none

module rsc_err_policy
  import rsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Events
  input wire logic tick_i,
  input wire logic err_i,
  input wire logic recover_i,
  input wire logic alarm_clr_i,
  // Settings
  input wire logic [1:0] policy_i,
  input wire logic [15:0] timer_ms_i,
  // Status
  output logic pending_o,
  output logic alarm_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_ALARM} rsc_pol_e;

  typedef struct packed {
    rsc_pol_e st;
    logic [15:0] cnt;
  } rsc_pol_s;

  rsc_pol_s s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      ST_IDLE: begin
        if (err_i) begin
          if (policy_i == POL_STOP) begin
            s_next.st = ST_ALARM;
          end else if (policy_i != POL_IGNORE) begin
            s_next.st = ST_HOLD;
            s_next.cnt = '0;
          end
        end
      end
      ST_HOLD: begin
        if (policy_i == POL_IGNORE) begin
          s_next.st = ST_IDLE;
        end else if (recover_i && (policy_i == POL_RECOVER)) begin
          s_next.st = ST_IDLE;
        end else if (s_reg.cnt >= timer_ms_i) begin
          s_next.st = ST_ALARM;
        end else if (tick_i) begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
      end
      ST_ALARM: begin
        // A fresh immediate error in the clearing cycle keeps the alarm
        if (alarm_clr_i && !(err_i && (policy_i == POL_STOP))) begin
          s_next.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_reg <= '{st: ST_IDLE, cnt: 16'h0000};
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign pending_o = (s_reg.st == ST_HOLD);
  assign alarm_o = (s_reg.st == ST_ALARM);

endmodule : rsc_err_policy

`default_nettype wire

//--- rsc_host_model.sv
// Host model for one port at frame-event level.
// Assumes requests and faults arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module rsc_host_model (
  // Clock
  input wire logic clk_i,
  // Frame events
  output logic req_o,
  output logic [7:0] addr_o,
  output logic err_o
);
  initial begin
    req_o = 1'b0;
    err_o = 1'b0;
    addr_o = 8'hA5;
  end

  task automatic send(input logic [7:0] a);
    @(posedge clk_i);
    req_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    req_o <= 1'b0;
    addr_o <= ~a;
  endtask : send

  task automatic fault();
    @(posedge clk_i);
    err_o <= 1'b1;
    @(posedge clk_i);
    err_o <= 1'b0;
  endtask : fault
endmodule : rsc_host_model

`default_nettype wire

//--- rsc_link_checker.sv
// Port checks on the link supervisor top.
// Assumes settings hold still while the enable is low.
`timescale 1ns/1ps
`default_nettype none

module rsc_link_checker (
  // Clock and drive state
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic running_i,
  input wire logic cmd_via_link_i,
  input wire logic freq_via_link_i,
  // Primary port inputs
  input wire logic [7:0] station_addr_port1_i,
  input wire logic [1:0] err_policy_port1_i,
  input wire logic [9:0] reply_delay_port1_i,
  input wire logic [1:0] proto_sel_port1_i,
  input wire logic req_done_port1_i,
  input wire logic [7:0] req_addr_port1_i,
  input wire logic rx_err_port1_i,
  // Outputs
  input wire logic tx_start_port1_o,
  input wire logic reply_wait_port1_o,
  input wire logic addr_ok_port1_o,
  input wire logic [3:0] data_bits_port1_o,
  input wire logic [1:0] parity_port1_o,
  input wire logic [1:0] stop_bits_port1_o,
  input wire logic err_pending_port1_o,
  input wire logic alarm_port1_o,
  input wire logic alarm_port2_o,
  input wire logic alarm_stop_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  wire logic [7:0] sa = station_addr_port1_i;
  wire logic [1:0] ps = proto_sel_port1_i;
  wire logic legal = (sa != 8'h00) && (ps == 2'h1 || (ps == 2'h0 && sa <= 8'hF7) || (ps == 2'h2 && sa <= 8'h1F));
  wire logic link_run = running_i && cmd_via_link_i && freq_via_link_i;

  addr_range_a: assert property (!$past(sys_rst_i) |-> addr_ok_port1_o == $past(legal))
    else $error("addr_ok wrong");
  no_reply_a: assert property (tx_start_port1_o |-> $past(addr_ok_port1_o))
    else $error("illegal reply");
  quick_reply_a: assert property (req_done_port1_i && req_addr_port1_i == sa && addr_ok_port1_o &&
    reply_delay_port1_i == 10'h000 |=> reply_wait_port1_o ##1 (tx_start_port1_o && !reply_wait_port1_o))
    else $error("reply mistimed");
  imm_alarm_a: assert property (rx_err_port1_i && $past(link_run && !sys_rst_i) && err_policy_port1_i == 2'h0 &&
    !err_pending_port1_o && !alarm_port1_o |-> ##2 alarm_port1_o)
    else $error("alarm missing");
  stop_follow_a: assert property (alarm_stop_o == $past(alarm_port1_o || alarm_port2_o))
    else $error("alarm stop wrong");
  ignore_pol_a: assert property ($rose(alarm_port1_o) |-> err_policy_port1_i != 2'h3)
    else $error("alarm under ignore");
  pend_pol_a: assert property (err_pending_port1_o |-> err_policy_port1_i inside {2'h1, 2'h2})
    else $error("hold under policy");
  loader_frame_a: assert property (!$past(sys_rst_i) && $past(ps) == 2'h1 |-> data_bits_port1_o == 4'h8 &&
    parity_port1_o == 2'h1 && stop_bits_port1_o == 2'h1)
    else $error("loader framing");
endmodule : rsc_link_checker

`default_nettype wire

//--- rsc_link_supervisor.sv
// Top of the two-port serial link configuration supervisor.
// Assumes the frame layer on the same clock reports complete requests and
// character or address errors as one-cycle pulses, and starts a reply on tx_start.
`timescale 1ns/1ps
`default_nettype none

module rsc_link_supervisor
  import rsc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Drive state
  input wire logic running_i,
  input wire logic cmd_via_link_i,
  input wire logic freq_via_link_i,
  // Primary port settings
  input wire logic [7:0] station_addr_port1_i,
  input wire logic [1:0] err_policy_port1_i,
  input wire logic [9:0] err_timer_port1_i,
  input wire logic [1:0] baud_sel_port1_i,
  input wire logic char_len_port1_i,
  input wire logic [1:0] parity_sel_port1_i,
  input wire logic stop_sel_port1_i,
  input wire logic [9:0] silence_timeout_port1_i,
  input wire logic [9:0] reply_delay_port1_i,
  input wire logic [1:0] proto_sel_port1_i,
  // Option port settings
  input wire logic [7:0] station_addr_port2_i,
  input wire logic [1:0] err_policy_port2_i,
  input wire logic [9:0] err_timer_port2_i,
  input wire logic [1:0] baud_sel_port2_i,
  input wire logic char_len_port2_i,
  input wire logic [1:0] parity_sel_port2_i,
  input wire logic stop_sel_port2_i,
  input wire logic [9:0] silence_timeout_port2_i,
  input wire logic [9:0] reply_delay_port2_i,
  input wire logic [1:0] proto_sel_port2_i,
  // Primary port frame events
  input wire logic req_done_port1_i,
  input wire logic [7:0] req_addr_port1_i,
  input wire logic rx_err_port1_i,
  input wire logic alarm_clr_port1_i,
  // Option port frame events
  input wire logic req_done_port2_i,
  input wire logic [7:0] req_addr_port2_i,
  input wire logic rx_err_port2_i,
  input wire logic alarm_clr_port2_i,
  // Primary port outputs
  output logic tx_start_port1_o,
  output logic reply_wait_port1_o,
  output logic addr_ok_port1_o,
  output logic [3:0] data_bits_port1_o,
  output logic [1:0] parity_port1_o,
  output logic [1:0] stop_bits_port1_o,
  output logic [DIV_W-1:0] baud_div_port1_o,
  output logic err_pending_port1_o,
  output logic alarm_port1_o,
  // Option port outputs
  output logic tx_start_port2_o,
  output logic reply_wait_port2_o,
  output logic addr_ok_port2_o,
  output logic [3:0] data_bits_port2_o,
  output logic [1:0] parity_port2_o,
  output logic [1:0] stop_bits_port2_o,
  output logic [DIV_W-1:0] baud_div_port2_o,
  output logic err_pending_port2_o,
  output logic alarm_port2_o,
  // Drive action
  output logic alarm_stop_o
);

  localparam int NP = 2;
  localparam int TW = $clog2(TICK_CYCLES_P + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES_P - 1);

  typedef struct packed {
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic link_run;
    logic [NP-1:0][15:0] sil_cnt;
    logic [NP-1:0] sil_err;
    logic [NP-1:0][15:0] reply_cnt;
    logic [NP-1:0] reply_busy;
    logic [NP-1:0] tx_start;
    logic [NP-1:0] err_evt;
    logic [NP-1:0] recov;
    logic alarm_stop;
  } rsc_top_s;

  rsc_top_s s_reg, s_next;

  // Per-port views of the separate ports
  logic [NP-1:0][7:0] station_addr;
  logic [NP-1:0][1:0] proto_sel;
  logic [NP-1:0][1:0] err_policy;
  logic [NP-1:0][15:0] err_ms;
  logic [NP-1:0][15:0] silence_ms;
  logic [NP-1:0][15:0] reply_ms;
  logic [NP-1:0] req_done;
  logic [NP-1:0][7:0] req_addr;
  logic [NP-1:0] rx_err;
  logic [NP-1:0] alarm_clr;
  logic [NP-1:0] addr_ok;
  logic [NP-1:0] alarm;
  logic [NP-1:0] pending;
  logic [NP-1:0] req_hit;
  logic [NP-1:0] req_own;

  assign station_addr = {station_addr_port2_i, station_addr_port1_i};
  assign proto_sel = {proto_sel_port2_i, proto_sel_port1_i};
  assign err_policy = {err_policy_port2_i, err_policy_port1_i};
  assign req_done = {req_done_port2_i, req_done_port1_i};
  assign req_addr = {req_addr_port2_i, req_addr_port1_i};
  assign rx_err = {rx_err_port2_i, rx_err_port1_i};
  assign alarm_clr = {alarm_clr_port2_i, alarm_clr_port1_i};

  assign err_ms[0] = rsc_to_ms(err_timer_port1_i, ERR_TIMER_MAX, ERR_UNIT_MS);
  assign err_ms[1] = rsc_to_ms(err_timer_port2_i, ERR_TIMER_MAX, ERR_UNIT_MS);
  assign silence_ms[0] = rsc_to_ms(silence_timeout_port1_i, SILENCE_MAX, SILENCE_UNIT_MS);
  assign silence_ms[1] = rsc_to_ms(silence_timeout_port2_i, SILENCE_MAX, SILENCE_UNIT_MS);
  assign reply_ms[0] = rsc_to_ms(reply_delay_port1_i, REPLY_DELAY_MAX, REPLY_UNIT_MS);
  assign reply_ms[1] = rsc_to_ms(reply_delay_port2_i, REPLY_DELAY_MAX, REPLY_UNIT_MS);

  // Framing decode; only the primary port accepts the loader protocol
  rsc_port_cfg #(
    .LOADER_OK(1'b1)
  ) u_cfg1 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .station_addr_i(station_addr_port1_i),
    .baud_sel_i(baud_sel_port1_i),
    .char_len_i(char_len_port1_i),
    .parity_sel_i(parity_sel_port1_i),
    .stop_sel_i(stop_sel_port1_i),
    .proto_sel_i(proto_sel_port1_i),
    .addr_ok_o(addr_ok[0]),
    .data_bits_o(data_bits_port1_o),
    .parity_o(parity_port1_o),
    .stop_bits_o(stop_bits_port1_o),
    .baud_div_o(baud_div_port1_o)
  );

  rsc_port_cfg #(
    .LOADER_OK(1'b0)
  ) u_cfg2 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .station_addr_i(station_addr_port2_i),
    .baud_sel_i(baud_sel_port2_i),
    .char_len_i(char_len_port2_i),
    .parity_sel_i(parity_sel_port2_i),
    .stop_sel_i(stop_sel_port2_i),
    .proto_sel_i(proto_sel_port2_i),
    .addr_ok_o(addr_ok[1]),
    .data_bits_o(data_bits_port2_o),
    .parity_o(parity_port2_o),
    .stop_bits_o(stop_bits_port2_o),
    .baud_div_o(baud_div_port2_o)
  );

  rsc_err_policy u_pol1 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .tick_i(s_reg.tick),
    .err_i(s_reg.err_evt[0]),
    .recover_i(s_reg.recov[0]),
    .alarm_clr_i(alarm_clr[0]),
    .policy_i(err_policy[0]),
    .timer_ms_i(err_ms[0]),
    .pending_o(pending[0]),
    .alarm_o(alarm[0])
  );

  rsc_err_policy u_pol2 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .tick_i(s_reg.tick),
    .err_i(s_reg.err_evt[1]),
    .recover_i(s_reg.recov[1]),
    .alarm_clr_i(alarm_clr[1]),
    .policy_i(err_policy[1]),
    .timer_ms_i(err_ms[1]),
    .pending_o(pending[1]),
    .alarm_o(alarm[1])
  );

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.tick_cnt == TICK_LAST) begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + TW'(1);
    end

    s_next.link_run = running_i && cmd_via_link_i && freq_via_link_i;
    s_next.alarm_stop = |alarm;

    for (int p = 0; p < NP; p++) begin
      // A request for this station, or a broadcast that is executed silently
      req_own[p] = req_done[p] && (req_addr[p] == station_addr[p]) && addr_ok[p];
      req_hit[p] = req_own[p] || (req_done[p] && rsc_addr_bcast(proto_sel[p], req_addr[p]));

      // Reply timing
      s_next.tx_start[p] = 1'b0;
      if (req_own[p]) begin
        s_next.reply_busy[p] = 1'b1;
        s_next.reply_cnt[p] = reply_ms[p];
      end else if (s_reg.reply_busy[p]) begin
        if (!addr_ok[p]) begin
          s_next.reply_busy[p] = 1'b0;
        end else if (s_reg.reply_cnt[p] == 16'h0000) begin
          s_next.reply_busy[p] = 1'b0;
          s_next.tx_start[p] = 1'b1;
        end else if (s_reg.tick) begin
          s_next.reply_cnt[p] = s_reg.reply_cnt[p] - 16'h0001;
        end
      end

      // Host silence watch; rearms after each timeout
      s_next.sil_err[p] = 1'b0;
      if (req_hit[p] || !s_reg.link_run || (silence_ms[p] == 16'h0000)) begin
        s_next.sil_cnt[p] = 16'h0000;
      end else if (s_reg.sil_cnt[p] >= silence_ms[p]) begin
        s_next.sil_cnt[p] = 16'h0000;
        s_next.sil_err[p] = 1'b1;
      end else if (s_reg.tick) begin
        s_next.sil_cnt[p] = s_reg.sil_cnt[p] + 16'h0001;
      end

      s_next.err_evt[p] = s_reg.link_run && (rx_err[p] || s_reg.sil_err[p]);
      s_next.recov[p] = req_hit[p];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign tx_start_port1_o = s_reg.tx_start[0];
  assign tx_start_port2_o = s_reg.tx_start[1];
  assign reply_wait_port1_o = s_reg.reply_busy[0];
  assign reply_wait_port2_o = s_reg.reply_busy[1];
  assign addr_ok_port1_o = addr_ok[0];
  assign addr_ok_port2_o = addr_ok[1];
  assign err_pending_port1_o = pending[0];
  assign err_pending_port2_o = pending[1];
  assign alarm_port1_o = alarm[0];
  assign alarm_port2_o = alarm[1];
  assign alarm_stop_o = s_reg.alarm_stop;

endmodule : rsc_link_supervisor

`default_nettype wire

//--- rsc_pkg.sv
// Constants, codes and decode helpers for the serial port configuration supervisor.
// Assumes a 250 MHz system clock; the frame layer lives outside this block.
// Function
// - Legal station address range and broadcast code depend on protocol.
// - Out-of-range station address means no reply is ever sent.
// - Errors count only while running with command and frequency from the link.
// - Policy 0: raise port alarm and stop at once.
// - Policy 1: run for the error timer, then alarm and stop.
// - Policy 2: run for the error timer; recovery cancels, else alarm stop.
// - Policy 3: keep running, never alarm stop for link errors.
// - Error timer spans 0.0 to 60.0 s; no request in time means error.
// - Baud code 0 to 3 gives 2400, 4800, 9600, 19200; host matches.
// - Length code 0 gives eight data bits, code 1 seven.
// - Parity none/even/odd/none; Modbus stop bits two for code 0, else one.
// - Other protocols: stop code 0 two bits, code 1 one bit.
// - Loader protocol forces eight bits, even parity, one stop bit.
// - Silence timeout of 1 to 60 s triggers the error policy.
// - Silence timeout of zero disables silence detection.
// - Reply starts after the response interval following a complete request.
// - Response interval spans 0.00 to 1.00 s.
// - Protocol 0 Modbus, 1 loader on primary port only, 2 general purpose.
// - Character: start bit 0, data, optional parity, stop bit 1.

package rsc_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Setting units expressed in millisecond ticks
  localparam int ERR_UNIT_MS = 100;
  localparam int REPLY_UNIT_MS = 10;
  localparam int SILENCE_UNIT_MS = 1000;
  localparam logic [9:0] ERR_TIMER_MAX = 10'h258;
  localparam logic [9:0] REPLY_DELAY_MAX = 10'h064;
  localparam logic [9:0] SILENCE_MAX = 10'h03C;

  localparam logic [1:0] PROTO_MODBUS = 2'h0;
  localparam logic [1:0] PROTO_LOADER = 2'h1;
  localparam logic [1:0] PROTO_GENERAL = 2'h2;

  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX_MODBUS = 8'hF7;
  localparam logic [7:0] ADDR_MAX_LOADER = 8'hFF;
  localparam logic [7:0] ADDR_MAX_GENERAL = 8'h1F;
  localparam logic [7:0] BCAST_MODBUS = 8'h00;
  localparam logic [7:0] BCAST_GENERAL = 8'h63;

  localparam logic [1:0] POL_STOP = 2'h0;
  localparam logic [1:0] POL_DELAY = 2'h1;
  localparam logic [1:0] POL_RECOVER = 2'h2;
  localparam logic [1:0] POL_IGNORE = 2'h3;

  localparam logic [1:0] PAR_SEL_NONE = 2'h0;
  localparam logic [1:0] PAR_SEL_EVEN = 2'h1;
  localparam logic [1:0] PAR_SEL_ODD = 2'h2;
  localparam logic LEN_SEL_8 = 1'b0;
  localparam logic STOP_SEL_2 = 1'b0;

  // Decoded framing presented to the character layer
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_7 = 4'h7;
  localparam logic [1:0] STOP_BITS_2 = 2'h2;
  localparam logic [1:0] STOP_BITS_1 = 2'h1;
  localparam logic [1:0] PAR_OUT_NONE = 2'h0;
  localparam logic [1:0] PAR_OUT_EVEN = 2'h1;
  localparam logic [1:0] PAR_OUT_ODD = 2'h2;

  localparam int BAUD_0 = 2400;
  localparam int BAUD_1 = 4800;
  localparam int BAUD_2 = 9600;
  localparam int BAUD_3 = 19200;
  localparam int DIV_W = 17;

  function automatic logic rsc_addr_legal(input logic [1:0] proto, input logic [7:0] addr);
    rsc_addr_legal = 1'b0;
    unique case (proto)
      PROTO_MODBUS: rsc_addr_legal = (addr >= ADDR_MIN) && (addr <= ADDR_MAX_MODBUS);
      PROTO_LOADER: rsc_addr_legal = (addr >= ADDR_MIN) && (addr <= ADDR_MAX_LOADER);
      PROTO_GENERAL: rsc_addr_legal = (addr >= ADDR_MIN) && (addr <= ADDR_MAX_GENERAL);
      default: rsc_addr_legal = 1'b0;
    endcase
  endfunction : rsc_addr_legal

  function automatic logic rsc_addr_bcast(input logic [1:0] proto, input logic [7:0] addr);
    rsc_addr_bcast = ((proto == PROTO_MODBUS) && (addr == BCAST_MODBUS)) ||
                     ((proto == PROTO_GENERAL) && (addr == BCAST_GENERAL));
  endfunction : rsc_addr_bcast

  function automatic logic [DIV_W-1:0] rsc_baud_div(input logic [1:0] code);
    rsc_baud_div = DIV_W'(CLK_HZ / BAUD_0);
    unique case (code)
      2'h0: rsc_baud_div = DIV_W'(CLK_HZ / BAUD_0);
      2'h1: rsc_baud_div = DIV_W'(CLK_HZ / BAUD_1);
      2'h2: rsc_baud_div = DIV_W'(CLK_HZ / BAUD_2);
      2'h3: rsc_baud_div = DIV_W'(CLK_HZ / BAUD_3);
    endcase
  endfunction : rsc_baud_div

  // Clamp a setting and scale it to millisecond ticks
  function automatic logic [15:0] rsc_to_ms(input logic [9:0] v, input logic [9:0] vmax, input int unit);
    logic [9:0] c;
    c = (v > vmax) ? vmax : v;
    rsc_to_ms = 16'(int'(c) * unit);
  endfunction : rsc_to_ms

endpackage : rsc_pkg

//--- rsc_port_cfg.sv
// Per-port framing and address decode, registered.
// Assumes configuration inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module rsc_port_cfg
  import rsc_pkg::*;
#(
  parameter bit LOADER_OK = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Settings
  input wire logic [7:0] station_addr_i,
  input wire logic [1:0] baud_sel_i,
  input wire logic char_len_i,
  input wire logic [1:0] parity_sel_i,
  input wire logic stop_sel_i,
  input wire logic [1:0] proto_sel_i,
  // Decoded framing
  output logic addr_ok_o,
  output logic [3:0] data_bits_o,
  output logic [1:0] parity_o,
  output logic [1:0] stop_bits_o,
  output logic [DIV_W-1:0] baud_div_o
);

  typedef struct packed {
    logic addr_ok;
    logic [3:0] data_bits;
    logic [1:0] parity;
    logic [1:0] stop_bits;
    logic [DIV_W-1:0] baud_div;
  } rsc_cfg_s;

  rsc_cfg_s s_reg, s_next;
  logic proto_ok;

  always_comb begin
    s_next = s_reg;
    proto_ok = (proto_sel_i == PROTO_MODBUS) || (proto_sel_i == PROTO_GENERAL) ||
               ((proto_sel_i == PROTO_LOADER) && LOADER_OK);
    s_next.addr_ok = proto_ok && rsc_addr_legal(proto_sel_i, station_addr_i);
    s_next.baud_div = rsc_baud_div(baud_sel_i);
    s_next.data_bits = (char_len_i == LEN_SEL_8) ? DATA_BITS_8 : DATA_BITS_7;
    unique case (parity_sel_i)
      PAR_SEL_EVEN: s_next.parity = PAR_OUT_EVEN;
      PAR_SEL_ODD: s_next.parity = PAR_OUT_ODD;
      default: s_next.parity = PAR_OUT_NONE;
    endcase
    if (proto_sel_i == PROTO_MODBUS) begin
      s_next.stop_bits = (parity_sel_i == PAR_SEL_NONE) ? STOP_BITS_2 : STOP_BITS_1;
    end else begin
      s_next.stop_bits = (stop_sel_i == STOP_SEL_2) ? STOP_BITS_2 : STOP_BITS_1;
    end
    if (proto_sel_i == PROTO_LOADER) begin
      s_next.data_bits = DATA_BITS_8;
      s_next.parity = PAR_OUT_EVEN;
      s_next.stop_bits = STOP_BITS_1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_reg <= '{addr_ok: 1'b0, data_bits: DATA_BITS_8, parity: PAR_OUT_NONE,
                 stop_bits: STOP_BITS_2, baud_div: DIV_W'(CLK_HZ / BAUD_0)};
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // Stop bits are sent at logic 1 after a logic 0 start bit by the character layer
  assign addr_ok_o = s_reg.addr_ok;
  assign data_bits_o = s_reg.data_bits;
  assign parity_o = s_reg.parity;
  assign stop_bits_o = s_reg.stop_bits;
  assign baud_div_o = s_reg.baud_div;

endmodule : rsc_port_cfg

`default_nettype wire

//--- testbench.sv
// Directed bench for the two-port link supervisor.
// Assumes a tick shortened to TICK cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
  localparam int TICK = 10;
  logic clk = 1'b0, rst = 1'b1, run = 1'b0, src = 1'b0, clr = 1'b0, clen = 1'b0, stp = 1'b0, ce = 1'b1;
  logic [7:0] addr = 8'h05;
  logic [1:0] pol = 2'h0, baud = 2'h0, par = 2'h0, proto = 2'h0, proto2 = 2'h0;
  logic [9:0] tmr = 10'h001, sil = 10'h000, dly = 10'h000;
  logic req1, er1, req2, er2, tx1, rw1, ok1, pe1, al1, ok2, al2, pe2, astop;
  logic [7:0] ra1, ra2;
  logic [3:0] db1, db2;
  logic [1:0] pr1, sb1;
  logic [16:0] bd1;
  int fail_count = 0, comparisons = 0;

  always #2 clk = ~clk;

  rsc_host_model u_host1 (.clk_i(clk), .req_o(req1), .addr_o(ra1), .err_o(er1));
  rsc_host_model u_host2 (.clk_i(clk), .req_o(req2), .addr_o(ra2), .err_o(er2));
  rsc_link_supervisor #(.TICK_CYCLES_P(TICK)) u_rsc_link_supervisor (
    .clk_i(clk), .sys_rst_i(rst), .ce_i(ce), .running_i(run), .cmd_via_link_i(src), .freq_via_link_i(src),
    .station_addr_port1_i(addr), .err_policy_port1_i(pol), .err_timer_port1_i(tmr), .baud_sel_port1_i(baud),
    .char_len_port1_i(clen), .parity_sel_port1_i(par), .stop_sel_port1_i(stp), .silence_timeout_port1_i(sil),
    .reply_delay_port1_i(dly), .proto_sel_port1_i(proto),
    .station_addr_port2_i(addr), .err_policy_port2_i(pol), .err_timer_port2_i(tmr), .baud_sel_port2_i(baud),
    .char_len_port2_i(clen), .parity_sel_port2_i(par), .stop_sel_port2_i(stp), .silence_timeout_port2_i(sil),
    .reply_delay_port2_i(dly), .proto_sel_port2_i(proto2),
    .req_done_port1_i(req1), .req_addr_port1_i(ra1), .rx_err_port1_i(er1), .alarm_clr_port1_i(clr),
    .req_done_port2_i(req2), .req_addr_port2_i(ra2), .rx_err_port2_i(er2), .alarm_clr_port2_i(clr),
    .tx_start_port1_o(tx1), .reply_wait_port1_o(rw1), .addr_ok_port1_o(ok1), .data_bits_port1_o(db1),
    .parity_port1_o(pr1), .stop_bits_port1_o(sb1), .baud_div_port1_o(bd1), .err_pending_port1_o(pe1),
    .alarm_port1_o(al1), .tx_start_port2_o(), .reply_wait_port2_o(), .addr_ok_port2_o(ok2),
    .data_bits_port2_o(db2), .parity_port2_o(), .stop_bits_port2_o(), .baud_div_port2_o(),
    .err_pending_port2_o(pe2), .alarm_port2_o(al2), .alarm_stop_o(astop));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_for(input bit sel, input int lim, output int n);
    for (n = 1; n < lim; n++) begin
      @(posedge clk);
      #1;
      if ((sel ? al1 : tx1) === 1'b1) break;
    end
  endtask : wait_for

  task automatic clear();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(2);
    `CHK("alarm cleared", 1'b0, al1)
  endtask : clear

  task automatic t_framing();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      baud <= 2'(i);
      par <= 2'(i);
      clen <= i[0];
      tick(2);
      `CHK("baud_div", 17'(250000000 / (2400 << i)), bd1)
      `CHK("data_bits", i[0] ? 4'h7 : 4'h8, db1)
      `CHK("parity", (i == 3) ? 2'h0 : 2'(i), pr1)
      `CHK("modbus stop", (i == 0) ? 2'h2 : 2'h1, sb1)
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      proto <= 2'h2;
      stp <= j[0];
      tick(2);
      `CHK("stop_bits", j ? 2'h1 : 2'h2, sb1)
    end
    @(posedge clk);
    ce <= 1'b0;
    baud <= 2'h0;
    tick(2);
    `CHK("frozen baud_div", 17'(250000000 / 19200), bd1)
    @(posedge clk);
    ce <= 1'b1;
    proto <= 2'h1;
    proto2 <= 2'h1;
    stp <= 1'b0;
    tick(2);
    `CHK("loader format", {4'h8, 4'h8, 2'h1, 2'h1}, {db2, db1, pr1, sb1})
  endtask : t_framing

  task automatic t_addr();
    logic [1:0] p [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [7:0] a [8] = '{8'h00, 8'hF7, 8'hF8, 8'hFF, 8'h00, 8'h1F, 8'h20, 8'h63};
    logic [7:0] e = 8'h2A;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      proto <= p[k];
      proto2 <= p[k];
      addr <= a[k];
      tick(2);
      `CHK("addr_ok", e[k], ok1)
      `CHK("port2 addr_ok", (p[k] == 2'h1) ? 1'b0 : e[k], ok2)
    end
  endtask : t_addr

  task automatic t_reply();
    int n;
    @(posedge clk);
    proto <= 2'h0;
    proto2 <= 2'h0;
    addr <= 8'h05;
    tick(2);
    u_host1.send(8'h05);
    #1;
    `CHK("reply_wait", 1'b1, rw1)
    wait_for(1'b0, 20, n);
    `CHK("reply cycle", 1, n)
    @(posedge clk);
    addr <= 8'hF8;
    u_host1.send(8'h00);
    u_host1.send(8'hF8);
    wait_for(1'b0, 20, n);
    `CHK("no reply", 20, n)
    @(posedge clk);
    addr <= 8'h05;
    dly <= 10'h002;
    tick(2);
    u_host1.send(8'h05);
    wait_for(1'b0, 400, n);
    `CHK("delayed reply", 1'b1, n >= 19 * TICK && n <= 20 * TICK + 3)
  endtask : t_reply

  task automatic t_policy();
    int n;
    @(posedge clk);
    run <= 1'b1;
    tick(2);
    u_host1.fault();
    tick(6);
    `CHK("error off link", 1'b0, al1)
    @(posedge clk);
    src <= 1'b1;
    tick(2);
    u_host1.fault();
    tick(2);
    `CHK("alarm", 1'b1, al1)
    tick(1);
    `CHK("alarm stop", 1'b1, astop)
    clear();
    @(posedge clk);
    pol <= 2'h1;
    u_host1.fault();
    tick(3);
    `CHK("pending", 1'b1, pe1)
    wait_for(1'b1, 1200, n);
    `CHK("held alarm", 1'b1, n >= 985 && n <= 1005)
    clear();
    @(posedge clk);
    pol <= 2'h2;
    u_host1.fault();
    tick(100);
    u_host1.send(8'h05);
    tick(1200);
    `CHK("recovered", 1'b0, al1 | pe1)
    @(posedge clk);
    pol <= 2'h3;
    u_host1.fault();
    tick(20);
    `CHK("ignore policy", 1'b0, al1 | pe1)
    @(posedge clk);
    pol <= 2'h0;
    u_host2.fault();
    tick(3);
    `CHK("port2 alarm only", 3'b010, {pe2, al2, al1})
    clear();
  endtask : t_policy

  task automatic t_silence();
    int n;
    @(posedge clk);
    sil <= 10'h001;
    u_host1.send(8'h05);
    wait_for(1'b1, 11000, n);
    `CHK("silence alarm", 1'b1, n >= 9990 && n <= 10020)
    @(posedge clk);
    sil <= 10'h000;
    clear();
    tick(11000);
    `CHK("silence off", 1'b0, al1 | al2)
  endtask : t_silence

  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    t_framing();
    t_addr();
    t_reply();
    t_policy();
    t_silence();
    end_sim();
  end

  initial begin
    #(4 * 60000);
    fail_count++;
    end_sim();
  end
endmodule : testbench

bind rsc_link_supervisor rsc_link_checker u_rsc_link_checker (.*);

`default_nettype wire
